// ===== src/epvc_pkg.sv
package epvc_pkg;

  // Opcodes and program check byte
  localparam logic [7:0] OP_AMV = 8'h80;
  localparam logic [7:0] OP_VCOM_READBACK = 8'h81;
  localparam logic [7:0] OP_VCOM_DC = 8'h82;
  localparam logic [7:0] OP_PARTIAL_WINDOW = 8'h90;
  localparam logic [7:0] OP_PARTIAL_ENTER = 8'h91;
  localparam logic [7:0] OP_PARTIAL_EXIT = 8'h92;
  localparam logic [7:0] OP_PROGRAM_MODE = 8'ha0;
  localparam logic [7:0] OP_ACTIVATE_PROG = 8'ha1;
  localparam logic [7:0] OP_NVM_READBACK = 8'ha2;
  localparam logic [7:0] OP_POWER_SAVING = 8'he3;
  localparam logic [7:0] PROGRAM_CHECK_CODE = 8'ha5;

  // Reset values and limits
  localparam logic [5:0] VCOM_DC_RESET = 6'h00;
  localparam logic WINDOW_SCAN_RESET = 1'b1;
  localparam logic [11:0] NVM_ADDR_MAX = 12'hfff;
  localparam logic [2:0] PW_LAST_PARAM = 3'h6;

  // AXI4-Lite register byte addresses and response codes
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VCOM = 8'h08;
  localparam logic [7:0] REG_HWIN = 8'h0c;
  localparam logic [7:0] REG_VWIN = 8'h10;
  localparam logic [7:0] REG_PWR = 8'h14;
  localparam logic [7:0] REG_NVM = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Timing
  localparam int CLK_MHZ = 125;
  localparam int PROG_TIME_US = 10;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int LINE_TIME_NS = 800;
  localparam int LINE_CYCLES = LINE_TIME_NS * CLK_MHZ / 1000;

  typedef enum logic [2:0] {
    EPVC_IDLE,
    EPVC_PWIN,
    EPVC_VDC,
    EPVC_PGM,
    EPVC_AMV,
    EPVC_PWS
  } epvc_cmd_t;

  typedef struct packed {
    logic sclk;
    logic sdin;
    logic cs_n;
    logic dc;
  } epvc_link_t;

  typedef struct packed {
    logic [4:0] horiz_start_bank;
    logic [4:0] horiz_end_bank;
    logic [8:0] vert_start_line;
    logic [8:0] vert_end_line;
    logic window_scan_mode;
  } epvc_window_t;

endpackage

// ===== src/epvc_core.sv
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
// Function
// RQ1: Vcom readback opcode returns one byte, measured code in low six bits.
// RQ2: Vcom code zero is -0.10 V, 0.05 V steps, up to code 3ah.
// RQ3: VCOM DC opcode takes one byte, low six bits, reset to code zero.
// RQ4: Auto-measure bit one starts Vcom sensing; zero does nothing.
// RQ5: Partial window opcode takes seven parameter bytes in fixed order.
// RQ6: Host gives horizontal banks in bits 7:3, 00h-13h, end above start.
// RQ7: Host gives 9-bit vertical lines 000h-127h, end above start.
// RQ8: Scan-mode zero scans window only; one (default) scans inside and outside.
// RQ9: Partial-in opcode enters partial display mode.
// RQ10: Partial-out opcode returns to normal display mode.
// RQ11: Program-mode opcode acts only when its check byte is a5h.
// RQ12: Program mode holds until hardware reset.
// RQ13: Activate-program opcode starts the memory programming sequence.
// RQ14: Busy flag stays zero while programming runs.
// RQ15: Memory readback gives a dummy byte then bytes from address zero upward.
// RQ16: Readback address never passes fffh.
// RQ17: Power saving opcode byte: upper nibble Vcom width, lower source width.
// RQ18: Power saving fires for the set width on each output polarity change.
// RQ19: Vcom power-saving width counts in line periods.
// RQ20: Busy status is active low.
// RQ21: Serial bytes shift in MSB first; command/data select routes them.
// RQ22: Source power-saving width also counts in line periods.
module epvc_core
  import epvc_pkg::*;
(
  input wire logic aclk, // 125 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire epvc_pkg::epvc_link_t link_in, // Raw serial pins
  input wire logic [5:0] vcom_measured, // Code from the Vcom sensor
  input wire logic vcom_polarity, // Vcom output polarity
  input wire logic source_polarity, // Source output polarity
  input wire logic [7:0] nvm_rdata, // Memory byte at nvm_addr
  output logic [7:0] read_byte, // Byte offered on the next read cycle
  output logic [11:0] nvm_addr, // Memory readback address
  output logic busy_n, // Low while programming
  output logic program_mode, // Program mode latched
  output logic program_strobe, // One-cycle programming start
  output logic auto_measure_trigger, // One-cycle sensing start
  output logic partial_mode, // Partial display active
  output logic window_scan_mode, // Scan outside window too
  output logic vcom_save, // Vcom power saving active
  output logic source_save, // Source power saving active
  output logic [5:0] common_dc_level, // VCOM DC code
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read data valid
  input wire logic s_axi_rready // AXI read data ready
);

  typedef struct packed {
    epvc_link_t sync1;
    epvc_link_t sync2;
    logic sclk_prev;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    epvc_cmd_t cmd;
    logic [2:0] param_idx;
    epvc_window_t win;
    logic [7:0] read_byte;
    logic [11:0] nvm_addr;
    logic nvm_reading;
    logic busy_n;
    logic program_mode;
    logic program_strobe;
    logic [15:0] prog_cnt;
    logic amv;
    logic partial_mode;
    logic [5:0] vdc;
    logic [3:0] vcom_w;
    logic [3:0] src_w;
    logic [1:0] pol_prev;
    logic [7:0] line_cnt;
    logic [3:0] vcom_left;
    logic [3:0] src_left;
    logic awr;
    logic wr;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
    logic vcom_save;
    logic src_save;
  } epvc_state_t;

  epvc_state_t st;
  epvc_state_t next_st;

  logic sclk_rise;
  logic byte_done;
  logic [7:0] rx_byte;
  logic line_tick;

  always_comb begin
    next_st = st;
    next_st.sync1 = link_in;
    next_st.sync2 = st.sync1;
    next_st.sclk_prev = st.sync2.sclk;
    next_st.program_strobe = 1'b0;
    next_st.amv = 1'b0;
    sclk_rise = st.sync2.sclk & ~st.sclk_prev & ~st.sync2.cs_n;
    rx_byte = {st.shreg[6:0], st.sync2.sdin};
    byte_done = sclk_rise && (st.bit_cnt == 3'h7);
    line_tick = (st.line_cnt == 8'(LINE_CYCLES - 1));

    // =================================================================
    // Serial receiver
    if (st.sync2.cs_n) begin
      next_st.bit_cnt = 3'h0;
    end else if (sclk_rise) begin
      next_st.shreg = rx_byte; // RQ21
      next_st.bit_cnt = st.bit_cnt + 3'h1;
    end

    // =================================================================
    // Command interpreter
    if (byte_done && !st.sync2.dc) begin // RQ21
      next_st.cmd = EPVC_IDLE;
      next_st.param_idx = 3'h0;
      next_st.nvm_reading = 1'b0;
      if (rx_byte == OP_VCOM_READBACK) begin
        next_st.read_byte = {2'b00, vcom_measured}; // RQ1 RQ2
      end else if (rx_byte == OP_VCOM_DC) begin
        next_st.cmd = EPVC_VDC;
      end else if (rx_byte == OP_AMV) begin
        next_st.cmd = EPVC_AMV;
      end else if (rx_byte == OP_PARTIAL_WINDOW) begin
        next_st.cmd = EPVC_PWIN;
      end else if (rx_byte == OP_PARTIAL_ENTER) begin
        next_st.partial_mode = 1'b1; // RQ9
      end else if (rx_byte == OP_PARTIAL_EXIT) begin
        next_st.partial_mode = 1'b0; // RQ10
      end else if (rx_byte == OP_PROGRAM_MODE) begin
        next_st.cmd = EPVC_PGM;
      end else if (rx_byte == OP_ACTIVATE_PROG && st.busy_n) begin
        next_st.program_strobe = 1'b1; // RQ13
        next_st.busy_n = 1'b0; // RQ14 RQ20
        next_st.prog_cnt = 16'(PROG_CYCLES - 1);
      end else if (rx_byte == OP_NVM_READBACK) begin
        next_st.read_byte = 8'h00; // RQ15
        next_st.nvm_addr = 12'h000;
        next_st.nvm_reading = 1'b1;
      end else if (rx_byte == OP_POWER_SAVING) begin
        next_st.cmd = EPVC_PWS;
      end
    end else if (byte_done) begin
      case (st.cmd)
        EPVC_VDC: begin
          next_st.vdc = rx_byte[5:0]; // RQ3
          next_st.cmd = EPVC_IDLE;
        end
        EPVC_AMV: begin
          next_st.amv = rx_byte[0]; // RQ4
          next_st.cmd = EPVC_IDLE;
        end
        EPVC_PGM: begin
          if (rx_byte == PROGRAM_CHECK_CODE) begin
            next_st.program_mode = 1'b1; // RQ11 RQ12
          end
          next_st.cmd = EPVC_IDLE;
        end
        EPVC_PWS: begin
          next_st.vcom_w = rx_byte[7:4]; // RQ17
          next_st.src_w = rx_byte[3:0];
          next_st.cmd = EPVC_IDLE;
        end
        EPVC_PWIN: begin
          case (st.param_idx) // RQ5
            3'h0: next_st.win.horiz_start_bank = rx_byte[7:3];
            3'h1: next_st.win.horiz_end_bank = rx_byte[7:3];
            3'h2: next_st.win.vert_start_line[8] = rx_byte[0];
            3'h3: next_st.win.vert_start_line[7:0] = rx_byte;
            3'h4: next_st.win.vert_end_line[8] = rx_byte[0];
            3'h5: next_st.win.vert_end_line[7:0] = rx_byte;
            default: next_st.win.window_scan_mode = rx_byte[0]; // RQ8
          endcase
          next_st.param_idx = st.param_idx + 3'h1;
          if (st.param_idx == PW_LAST_PARAM) begin
            next_st.cmd = EPVC_IDLE;
          end
        end
        default: begin
          if (st.nvm_reading) begin
            // Data bytes clock the readback forward
            next_st.read_byte = nvm_rdata; // RQ15
            if (st.nvm_addr != NVM_ADDR_MAX) begin
              next_st.nvm_addr = st.nvm_addr + 12'h001; // RQ16
            end
          end
        end
      endcase
    end

    // =================================================================
    // Programming sequence
    if (!st.busy_n) begin
      if (st.prog_cnt == 16'h0000) begin
        next_st.busy_n = 1'b1; // RQ14
      end else begin
        next_st.prog_cnt = st.prog_cnt - 16'h0001;
      end
    end

    // =================================================================
    // Power saving, counted in line periods
    // A polarity change starts a fresh line, so each saving window is whole lines;
    // a change on one output stretches the other's current line
    if (line_tick || ({vcom_polarity, source_polarity} != st.pol_prev)) begin
      next_st.line_cnt = 8'h00; // RQ19 RQ22
    end else begin
      next_st.line_cnt = st.line_cnt + 8'h01;
    end
    next_st.pol_prev = {vcom_polarity, source_polarity};
    if (vcom_polarity != st.pol_prev[1]) begin
      next_st.vcom_left = st.vcom_w; // RQ18
    end else if (line_tick && st.vcom_left != 4'h0) begin
      next_st.vcom_left = st.vcom_left - 4'h1; // RQ19
    end
    if (source_polarity != st.pol_prev[0]) begin
      next_st.src_left = st.src_w; // RQ18
    end else if (line_tick && st.src_left != 4'h0) begin
      next_st.src_left = st.src_left - 4'h1; // RQ22
    end

    // =================================================================
    // AXI4-Lite slave
    if (s_axi_awvalid && !st.awr) begin
      next_st.awr = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wr) begin
      next_st.wr = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    if (st.awr && st.wr && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.awaddr == REG_CTRL) begin
        if (st.wdata[0]) begin
          next_st.amv = 1'b1; // RQ4
        end
        if (st.wdata[1]) begin
          next_st.partial_mode = 1'b1; // RQ9
        end else if (st.wdata[2]) begin
          next_st.partial_mode = 1'b0; // RQ10
        end
      end else if (st.awaddr == REG_VCOM) begin
        next_st.vdc = st.wdata[5:0]; // RQ3
      end else if (st.awaddr == REG_PWR) begin
        next_st.vcom_w = st.wdata[7:4]; // RQ17
        next_st.src_w = st.wdata[3:0];
      end else if (st.awaddr == REG_STATUS || st.awaddr == REG_HWIN ||
                   st.awaddr == REG_VWIN || st.awaddr == REG_NVM) begin
        next_st.bresp = RESP_OKAY;
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awr = 1'b0;
      next_st.wr = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (s_axi_araddr == REG_CTRL) begin
        next_st.rdata = {29'h0, 2'b00, st.win.window_scan_mode};
      end else if (s_axi_araddr == REG_STATUS) begin
        next_st.rdata = {28'h0, st.partial_mode, st.program_mode, st.nvm_reading, st.busy_n}; // RQ20
      end else if (s_axi_araddr == REG_VCOM) begin
        next_st.rdata = {18'h0, vcom_measured, 2'b00, st.vdc};
      end else if (s_axi_araddr == REG_HWIN) begin
        next_st.rdata = {19'h0, st.win.horiz_end_bank, 3'b000, st.win.horiz_start_bank};
      end else if (s_axi_araddr == REG_VWIN) begin
        next_st.rdata = {7'h0, st.win.vert_end_line, 7'h0, st.win.vert_start_line};
      end else if (s_axi_araddr == REG_PWR) begin
        next_st.rdata = {24'h0, st.vcom_w, st.src_w};
      end else if (s_axi_araddr == REG_NVM) begin
        next_st.rdata = {20'h0, st.nvm_addr};
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    if (!aresetn) begin
      next_st = '0;
      next_st.sync1.cs_n = 1'b1;
      next_st.sync2.cs_n = 1'b1;
      next_st.busy_n = 1'b1;
      next_st.vdc = VCOM_DC_RESET; // RQ3
      next_st.win.window_scan_mode = WINDOW_SCAN_RESET; // RQ8
      next_st.program_mode = 1'b0; // RQ12
      // Track the pins through reset so leaving it shows no false polarity change
      next_st.pol_prev = {vcom_polarity, source_polarity};
    end
    // Registered copies keep every output straight from a flop
    next_st.awready = ~next_st.awr;
    next_st.wready = ~next_st.wr;
    next_st.arready = ~next_st.rvalid;
    next_st.vcom_save = (next_st.vcom_left != 4'h0); // RQ18
    next_st.src_save = (next_st.src_left != 4'h0); // RQ18
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // =================================================================
  // Outputs, all straight from state flops
  assign read_byte = st.read_byte;
  assign nvm_addr = st.nvm_addr;
  assign busy_n = st.busy_n;
  assign program_mode = st.program_mode;
  assign program_strobe = st.program_strobe;
  assign auto_measure_trigger = st.amv;
  assign partial_mode = st.partial_mode;
  assign window_scan_mode = st.win.window_scan_mode;
  assign vcom_save = st.vcom_save;
  assign source_save = st.src_save;
  assign common_dc_level = st.vdc;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

endmodule

// ===== test/epvc_core_properties.sv
`timescale 1ns/100ps
// ==========================================
// Port checker for the command decoder
module epvc_core_properties (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic busy_n, // Busy, active low
  input wire logic program_mode, // Program mode level
  input wire logic program_strobe, // Programming start
  input wire logic auto_measure_trigger, // Sensing start
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Programming lasts far longer than eight cycles, so a short dip is a fault
  sequence s_prog_run;
    !busy_n [*8];
  endsequence
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_busy_start: assert property (program_strobe |-> ##[1:4] !busy_n)
    else $error("busy did not fall after programming start");
  a_busy_holds: assert property ($fell(busy_n) |-> s_prog_run)
    else $error("busy released too early");
  a_pgm_sticky: assert property (program_mode |=> program_mode)
    else $error("program mode dropped without reset");
  a_trig_pulse: assert property (auto_measure_trigger |=> !auto_measure_trigger)
    else $error("sensing trigger longer than one cycle");
  a_strobe_pulse: assert property (program_strobe |=> !program_strobe)
    else $error("programming strobe longer than one cycle");
  a_write_resp: assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
endmodule

bind epvc_core epvc_core_properties i_props (.aclk(aclk), .aresetn(aresetn), .busy_n(busy_n),
  .program_mode(program_mode), .program_strobe(program_strobe), .auto_measure_trigger(auto_measure_trigger),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// ===== test/epvc_host_model.sv
`timescale 1ns/100ps
// ==========================================
// Host side of the serial link
module epvc_host_model (
  input wire logic aclk, // Bench clock
  output epvc_pkg::epvc_link_t link // Serial pins
);
  import epvc_pkg::*;
  initial link = '{sclk: 1'b0, sdin: 1'b0, cs_n: 1'b1, dc: 1'b0};
  // One byte per frame; serial clock idles low between frames, 64 ns period
  task automatic send(input logic dc_bit, input logic [7:0] b);
    link.cs_n <= 1'b0;
    link.dc <= dc_bit;
    for (int i = 7; i >= 0; i--) begin
      link.sdin <= b[i];
      repeat (4) @(posedge aclk);
      link.sclk <= 1'b1;
      repeat (4) @(posedge aclk);
      link.sclk <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    link.cs_n <= 1'b1;
    // Released data line shows the inverse, never a stale bit
    link.sdin <= ~b[0];
    link.dc <= ~dc_bit;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import epvc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  epvc_link_t link;
  logic [5:0] vmeas = 6'h2a;
  logic vpol = 1'b0;
  logic spol = 1'b0;
  logic [7:0] nvm_rdata = 8'h00;
  logic [7:0] read_byte;
  logic [11:0] nvm_addr;
  logic busy_n, program_mode_cmd, strobe, amt, partial_mode, scan, vsave, ssave;
  logic [5:0] dc_lvl;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int check_count = 0;
  int trig_cnt = 0;
  int strobe_cnt = 0;
  logic [1:0] wr_resp = 2'b00;
  // ==========================================
  // Clock, memory contents, partner
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) nvm_rdata <= {nvm_addr[3:0], 4'ha};
  always @(posedge aclk) if (amt === 1'b1) trig_cnt <= trig_cnt + 1;
  always @(posedge aclk) if (strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
  epvc_host_model i_host (.aclk(aclk), .link(link));
  epvc_core i_epvc_core (.aclk(aclk), .aresetn(aresetn), .link_in(link), .vcom_measured(vmeas),
    .vcom_polarity(vpol), .source_polarity(spol), .nvm_rdata(nvm_rdata), .read_byte(read_byte),
    .nvm_addr(nvm_addr), .busy_n(busy_n), .program_mode(program_mode_cmd), .program_strobe(strobe),
    .auto_measure_trigger(amt), .partial_mode(partial_mode), .window_scan_mode(scan), .vcom_save(vsave),
    .source_save(ssave), .common_dc_level(dc_lvl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ==========================================
  // Report and compare
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_span(input string nm, input int exp, input int got, input int tol);
    check_count++;
    if (got < exp - tol || got > exp + tol) begin
      error_cnt++;
      $display("FAIL %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // ==========================================
  // Register bus master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    wr_resp = bresp;
    bready <= 1'b0;
    if (n >= 100) begin
      error_cnt++;
      stop_test();
    end
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) begin
      error_cnt++;
      stop_test();
    end
    @(posedge aclk);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset_vals();
    chk("busy_n", 1'h1, busy_n);
    chk("partial_mode", 1'h0, partial_mode);
    chk("window_scan_mode", 1'h1, scan);
    chk("common_dc_level", 6'h00, dc_lvl);
  endtask
  task automatic t_vcom();
    i_host.send(1'b0, OP_VCOM_DC);
    i_host.send(1'b1, 8'hfa);
    chk("common_dc_level", 6'h3a, dc_lvl);
    i_host.send(1'b0, OP_VCOM_READBACK);
    chk("vcom_readback", 6'h2a, read_byte[5:0]);
  endtask
  task automatic t_amv();
    int c0;
    c0 = trig_cnt;
    i_host.send(1'b0, OP_AMV);
    i_host.send(1'b1, 8'h00);
    chk("trigger_count", c0, trig_cnt);
    i_host.send(1'b0, OP_AMV);
    i_host.send(1'b1, 8'h01);
    chk("trigger_count", c0 + 1, trig_cnt);
  endtask
  task automatic t_window();
    logic [7:0] wb [7] = '{8'h10, 8'h9f, 8'h00, 8'h10, 8'h01, 8'h27, 8'h00};
    i_host.send(1'b0, OP_PARTIAL_WINDOW);
    foreach (wb[i]) i_host.send(1'b1, wb[i]);
    chk("window_scan_mode", 1'h0, scan);
    i_host.send(1'b0, OP_PARTIAL_ENTER);
    chk("partial_mode", 1'h1, partial_mode);
    i_host.send(1'b0, OP_PARTIAL_EXIT);
    chk("partial_mode", 1'h0, partial_mode);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    int c0;
    c0 = trig_cnt;
    axi_write(REG_CTRL, 32'h2);
    chk("write_resp", RESP_OKAY, wr_resp);
    axi_read(REG_STATUS, d, r);
    chk("status_partial", 1'h1, d[3]);
    chk("status_idle", 1'h1, d[0]);
    axi_write(REG_CTRL, 32'h4);
    chk("partial_mode", 1'h0, partial_mode);
    axi_write(REG_CTRL, 32'h1);
    chk("trigger_count", c0 + 1, trig_cnt);
    axi_write(REG_VCOM, 32'h15);
    chk("common_dc_level", 6'h15, dc_lvl);
    axi_read(REG_VCOM, d, r);
    chk("vcom_reg", 32'h0000_2a15, d);
    axi_read(REG_HWIN, d, r);
    chk("horiz_banks", 32'h0000_1302, d);
    axi_read(REG_VWIN, d, r);
    chk("vert_lines", 32'h0127_0010, d);
    axi_write(8'h40, 32'h0);
    chk("unmapped_wresp", RESP_SLVERR, wr_resp);
    axi_read(8'h40, d, r);
    chk("unmapped_resp", RESP_SLVERR, r);
  endtask
  task automatic t_pws();
    int nv;
    int ns;
    nv = 0;
    ns = 0;
    i_host.send(1'b0, OP_POWER_SAVING);
    i_host.send(1'b1, 8'h21);
    vpol <= ~vpol;
    spol <= ~spol;
    // Window outlasts both widths so each pulse is counted whole
    for (int i = 0; i < 400; i++) begin
      @(posedge aclk);
      if (vsave === 1'b1) nv++;
      if (ssave === 1'b1) ns++;
    end
    chk_span("vcom_save_cycles", 2 * LINE_CYCLES, nv, 3);
    chk_span("source_save_cycles", LINE_CYCLES, ns, 3);
  endtask
  task automatic t_nvm();
    i_host.send(1'b0, OP_NVM_READBACK);
    chk("dummy_byte", 8'h00, read_byte);
    chk("nvm_addr", 12'h000, nvm_addr);
    i_host.send(1'b1, 8'h00);
    chk("first_byte", 8'h0a, read_byte);
    chk("nvm_addr", 12'h001, nvm_addr);
  endtask
  task automatic t_program();
    int n;
    n = 0;
    i_host.send(1'b0, OP_PROGRAM_MODE);
    i_host.send(1'b1, 8'h5a);
    chk("program_mode", 1'h0, program_mode_cmd);
    i_host.send(1'b0, OP_PROGRAM_MODE);
    i_host.send(1'b1, PROGRAM_CHECK_CODE);
    chk("program_mode", 1'h1, program_mode_cmd);
    i_host.send(1'b0, OP_ACTIVATE_PROG);
    chk("busy_n", 1'h0, busy_n);
    // A second start while busy must be refused; its frame takes 72 cycles
    i_host.send(1'b0, OP_ACTIVATE_PROG);
    chk("program_starts", 1, strobe_cnt);
    while (busy_n !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk_span("busy_cycles", PROG_CYCLES - 80, n, 2);
    if (n >= 3000) begin
      error_cnt++;
      stop_test();
    end
    chk("program_mode", 1'h1, program_mode_cmd);
    do_reset();
    chk("program_mode", 1'h0, program_mode_cmd);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_vals();
    t_vcom();
    t_amv();
    t_window();
    t_regs();
    t_pws();
    t_nvm();
    t_program();
    stop_test();
  end
endmodule
